// ==== design/switch_port_forwarding_policy.sv ====
`timescale 1ns/10ps
`include "fwd_policy_consts.svh"

module switch_port_forwarding_policy #(
    parameter int NUM_PORTS = 5,
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys,                      // Core clock, 125 MHz
    input wire logic srst,                         // Synchronous reset, high
    input wire logic psel,                         // APB select
    input wire logic penable,                      // APB access phase
    input wire logic pwrite,                       // APB direction
    input wire logic [ADDR_W-1:0] paddr,           // APB byte address
    input wire logic [31:0] pwdata,                // APB write data
    output logic pready,                           // APB ready
    output logic [31:0] prdata,                    // APB read data
    output logic pslverr,                          // APB error, unmapped
    input fwd_policy_pkg::frame_req_t frame_req,   // Frame to classify
    output fwd_policy_pkg::frame_dec_t frame_dec,  // Decision, one cycle later
    output fwd_policy_pkg::queue_code_t [4:0] queue_code  // Per-port queue arrangement
);
    import fwd_policy_pkg::*;

    localparam logic [7:0] CTL1_IDX [5] = '{
        `PORT1_MIRROR_MEMBERSHIP_IDX, `PORT2_MIRROR_MEMBERSHIP_IDX,
        `PORT3_MIRROR_MEMBERSHIP_IDX, `PORT4_MIRROR_MEMBERSHIP_IDX,
        `PORT5_MIRROR_MEMBERSHIP_IDX
    };
    localparam logic [7:0] CTL2_IDX [5] = '{
        `PORT1_PRIORITY_CEILING_CTL_IDX, `PORT2_PRIORITY_CEILING_CTL_IDX,
        `PORT3_PRIORITY_CEILING_CTL_IDX, `PORT4_PRIORITY_CEILING_CTL_IDX,
        `PORT5_PRIORITY_CEILING_CTL_IDX
    };

    state_t st_q;
    state_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    logic [7:0] reg_idx;
    logic word_aligned;
    logic [4:0] hit_ctl1;
    logic [4:0] hit_ctl2;
    logic [4:0] hit_qctl;
    logic [4:0] hit_tag;
    logic mapped;
    logic setup_phase;
    logic write_take;

    assign reg_idx = paddr[9:2];
    assign word_aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_dec
            localparam logic [3:0] PNIB = 4'(gp + 1);
            assign hit_ctl1[gp] = word_aligned && (reg_idx == CTL1_IDX[gp]);
            assign hit_ctl2[gp] = word_aligned && (reg_idx == CTL2_IDX[gp]);
            assign hit_qctl[gp] = word_aligned && (reg_idx == {PNIB, `PORT_QUEUE_CTL_SUB});
            assign hit_tag[gp] = word_aligned && (reg_idx == {PNIB, `PORT_DEFAULT_TAG_HI_SUB});
        end
    endgenerate

    assign mapped = |{hit_ctl1, hit_ctl2, hit_qctl, hit_tag};
    assign setup_phase = psel && !penable;
    // Read data was loaded during setup, so the access phase never waits
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign write_take = psel && penable && pwrite && mapped;
    assign prdata = st_q.prdata;

    ////////////////////////////////////////////////////////////////////////
    // Per-port policy views

    logic [4:0] monitor_dest;
    logic [4:0] rx_monitor;
    logic [4:0] tx_monitor;
    logic [4:0] ceiling_en;
    logic [4:0][2:0] default_prio;

    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_view
            assign monitor_dest[gp] = st_q.mirror_membership[gp][`MONITOR_DEST_BIT];
            assign rx_monitor[gp] = st_q.mirror_membership[gp][`RX_MONITOR_BIT];
            assign tx_monitor[gp] = st_q.mirror_membership[gp][`TX_MONITOR_BIT];
            assign ceiling_en[gp] = st_q.priority_ceiling_ctl[gp][`CEILING_EN_BIT];
            assign default_prio[gp] =
                st_q.default_tag_hi[gp][`DEFAULT_PRIO_MSB:`DEFAULT_PRIO_LSB];
            assign queue_code[gp] = queue_code_t'({st_q.queue_ctl[gp][`QUEUE_HIGH_BIT],
                st_q.queue_ctl[gp][`QUEUE_SPLIT_BIT]});
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [2:0] src;
        logic [4:0] member;
        logic [4:0] normal;
        logic [4:0] mon_copy;
        logic monitored;
        logic [2:0] prio;

        st_d = st_q;
        src = 3'h0;
        member = 5'h00;
        normal = 5'h00;
        mon_copy = 5'h00;
        monitored = 1'b0;
        prio = 3'h0;

        // Register writes take effect at the access edge only
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (write_take && hit_ctl1[p]) begin
                st_d.mirror_membership[p] = pwdata[7:0];
            end
            if (write_take && hit_ctl2[p]) begin
                st_d.priority_ceiling_ctl[p] = pwdata[7:0];
            end
            if (write_take && hit_qctl[p]) begin
                st_d.queue_ctl[p] = {6'h00, pwdata[1:0]};
            end
            if (write_take && hit_tag[p]) begin
                st_d.default_tag_hi[p] = pwdata[7:0];
            end
        end

        // Read data captured in setup; unmapped reads return zero
        if (setup_phase) begin
            st_d.prdata = 32'h0000_0000;
            for (int p = 0; p < NUM_PORTS; p++) begin
                if (hit_ctl1[p]) begin
                    st_d.prdata = {24'h00_0000, st_q.mirror_membership[p]};
                end
                if (hit_ctl2[p]) begin
                    st_d.prdata = {24'h00_0000, st_q.priority_ceiling_ctl[p]};
                end
                if (hit_qctl[p]) begin
                    st_d.prdata = {24'h00_0000, st_q.queue_ctl[p]};
                end
                if (hit_tag[p]) begin
                    st_d.prdata = {24'h00_0000, st_q.default_tag_hi[p]};
                end
            end
        end

        // Frame decision
        src = (frame_req.src_port < 3'(NUM_PORTS)) ? frame_req.src_port : 3'h0;
        member = st_q.mirror_membership[src][`MEMBER_MSB:0];
        // Illegal source port forwards nowhere
        if (frame_req.src_port >= 3'(NUM_PORTS)) begin
            member = 5'h00;
        end
        normal = frame_req.dest_mask & member;
        // Illegal source port is never mirrored, so no copy leaks out
        monitored = (frame_req.src_port < 3'(NUM_PORTS))
            && (rx_monitor[src] || ((normal & tx_monitor) != 5'h00));
        // Copy never goes back out of the receiving port
        mon_copy = monitored ? (monitor_dest & ~(5'h01 << src)) : 5'h00;
        // OR merge avoids a duplicate on the monitor port
        st_d.dec.fwd_mask = normal | mon_copy;
        st_d.dec.monitored = monitored && (frame_req.src_port < 3'(NUM_PORTS));
        st_d.dec.valid = frame_req.valid;

        prio = frame_req.user_prio;
        if (ceiling_en[src] && (frame_req.user_prio > default_prio[src])) begin
            prio = default_prio[src];
        end
        st_d.dec.user_prio = prio;

        for (int p = 0; p < NUM_PORTS; p++) begin
            unique case (queue_code[p])
                QUEUES_FOUR: st_d.dec.egress_queue[p] = prio[2:1];
                QUEUES_TWO: st_d.dec.egress_queue[p] = {1'b0, prio[2]};
                // Reserved code falls back to one queue
                QUEUES_ONE, QUEUES_RSVD: st_d.dec.egress_queue[p] = 2'h0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                st_q.mirror_membership[p] <= `MIRROR_MEMBERSHIP_RST;
                st_q.priority_ceiling_ctl[p] <= `PRIORITY_CEILING_RST;
                st_q.queue_ctl[p] <= `QUEUE_CTL_RST;
                st_q.default_tag_hi[p] <= `DEFAULT_TAG_HI_RST;
            end
            st_q.prdata <= 32'h0000_0000;
            st_q.dec <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign frame_dec = st_q.dec;

endmodule : switch_port_forwarding_policy

// ==== design/fwd_policy_consts.svh ====
// What this block does
// - Each port's egress queue code is {queue high bit, queue split bit}; 10 means four queues, 11 is reserved.
// - Queue code 01 splits the port's output queue into two priority queues.
// - Queue code 00 uses one output queue, so frames leave with no priority ordering.
// - Bit 7 of a port's mirror and membership register makes that port the monitor destination.
// - Bit 6 marks every frame received on the port as monitored and copies it to the monitor port.
// - Bit 5 marks every frame sent on the port as monitored and copies it to the monitor port.
// - Bits 4 to 0 hold the port's membership mask, bit n-1 for port n, all ones after reset.
// - A frame goes only to destinations inside its source port's membership mask; the monitor copy is not masked by it.
// - With the ceiling bit 7 set, a user priority above the port default is replaced by it.
// - With the ceiling bit clear, the user priority passes unchanged.
// - The port default priority is bits 7 to 5 of the upper default tag byte.
`ifndef FWD_POLICY_CONSTS_SVH
`define FWD_POLICY_CONSTS_SVH

// Register indices; byte address is four times the index
`define PORT1_MIRROR_MEMBERSHIP_IDX 8'h11
`define PORT1_PRIORITY_CEILING_CTL_IDX 8'h12
`define PORT2_MIRROR_MEMBERSHIP_IDX 8'h21
`define PORT2_PRIORITY_CEILING_CTL_IDX 8'h22
`define PORT3_MIRROR_MEMBERSHIP_IDX 8'h31
`define PORT3_PRIORITY_CEILING_CTL_IDX 8'h32
`define PORT4_MIRROR_MEMBERSHIP_IDX 8'h41
`define PORT4_PRIORITY_CEILING_CTL_IDX 8'h42
`define PORT5_MIRROR_MEMBERSHIP_IDX 8'h51
`define PORT5_PRIORITY_CEILING_CTL_IDX 8'h52
`define PORT_QUEUE_CTL_SUB 4'h0
`define PORT_DEFAULT_TAG_HI_SUB 4'h3

// Field positions
`define MONITOR_DEST_BIT 7
`define RX_MONITOR_BIT 6
`define TX_MONITOR_BIT 5
`define MEMBER_MSB 4
`define CEILING_EN_BIT 7
`define QUEUE_SPLIT_BIT 0
`define QUEUE_HIGH_BIT 1
`define DEFAULT_PRIO_MSB 7
`define DEFAULT_PRIO_LSB 5

// Reset values
`define MIRROR_MEMBERSHIP_RST 8'h1F
`define PRIORITY_CEILING_RST 8'h00
`define QUEUE_CTL_RST 8'h00
`define DEFAULT_TAG_HI_RST 8'h00

`endif

// ==== design/fwd_policy_pkg.sv ====
package fwd_policy_pkg;

    typedef enum logic [1:0] {
        QUEUES_ONE,
        QUEUES_TWO,
        QUEUES_FOUR,
        QUEUES_RSVD
    } queue_code_t;

    // Frame descriptor offered by the lookup stage
    typedef struct packed {
        logic valid;
        logic [2:0] src_port;   // 0..4 for ports 1..5
        logic [4:0] dest_mask;  // bit n-1 for port n
        logic [2:0] user_prio;
    } frame_req_t;

    // Forwarding decision handed to the queue manager
    typedef struct packed {
        logic valid;
        logic [4:0] fwd_mask;
        logic monitored;
        logic [2:0] user_prio;
        logic [4:0][1:0] egress_queue;
    } frame_dec_t;

    typedef struct packed {
        logic [4:0][7:0] mirror_membership;
        logic [4:0][7:0] priority_ceiling_ctl;
        logic [4:0][7:0] queue_ctl;
        logic [4:0][7:0] default_tag_hi;
        logic [31:0] prdata;
        frame_dec_t dec;
    } state_t;

endpackage : fwd_policy_pkg

// ==== tb/switch_port_forwarding_policy_monitor.sv ====
`timescale 1ns/10ps
module switch_port_forwarding_policy_monitor #(
    parameter int ADDR_W = 12
) (
    input wire logic clk_sys, // Clock
    input wire logic srst, // Reset
    input wire logic psel, // Select
    input wire logic penable, // Access
    input wire logic pwrite, // Direction
    input wire logic [ADDR_W-1:0] paddr, // Address
    input wire logic [31:0] pwdata, // Write data
    input wire logic pready, // Ready
    input wire logic [31:0] prdata, // Read data
    input wire logic pslverr, // Error
    input fwd_policy_pkg::frame_req_t frame_req, // Frame in
    input fwd_policy_pkg::frame_dec_t frame_dec, // Decision
    input fwd_policy_pkg::queue_code_t [4:0] queue_code // Queue codes
);
    import fwd_policy_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    AST_MEMBER:
    assert property (frame_dec.valid && !frame_dec.monitored |->
        (frame_dec.fwd_mask & ~$past(frame_req.dest_mask)) == 5'h00) else $error("Bad fwd");
    AST_NO_SELF:
    assert property (frame_dec.valid |-> (frame_dec.fwd_mask & ~$past(frame_req.dest_mask)
        & (5'h01 << $past(frame_req.src_port))) == 5'h00) else $error("Copy to source");
    AST_CEIL:
    assert property (frame_dec.valid |-> frame_dec.user_prio <= $past(frame_req.user_prio))
        else $error("Prio raised");
    AST_RST:
    assert property (disable iff (1'b0) srst |=> queue_code == '0 && !frame_dec.valid)
        else $error("Reset state");
    AST_ERR:
    assert property (pslverr |-> psel && penable) else $error("Error outside access");
    for (genvar p = 0; p < 5; p++) begin : g_q
        AST_Q4:
        assert property ($past(queue_code[p]) == QUEUES_FOUR && frame_dec.valid |->
            frame_dec.egress_queue[p] == frame_dec.user_prio[2:1]) else $error("Four q");
        AST_Q2:
        assert property ($past(queue_code[p]) == QUEUES_TWO && frame_dec.valid |->
            frame_dec.egress_queue[p] == {1'b0, frame_dec.user_prio[2]}) else $error("Two q");
        AST_Q1:
        assert property ($past(queue_code[p][1]) == $past(queue_code[p][0]) && frame_dec.valid
            |-> frame_dec.egress_queue[p] == 2'b00) else $error("One q");
    end
    C_MON: cover property (frame_dec.valid && frame_dec.monitored);
    C_ERR: cover property (pslverr);
    C_CLAMP: cover property (frame_dec.valid && frame_dec.user_prio < $past(frame_req.user_prio));
endmodule : switch_port_forwarding_policy_monitor
////////////////////////////////////////
bind switch_port_forwarding_policy switch_port_forwarding_policy_monitor #(
    .ADDR_W(ADDR_W)) i_mon (.*);

// ==== tb/switch_port_forwarding_policy_tb_top.sv ====
`timescale 1ns/10ps
module switch_port_forwarding_policy_tb_top;
    import fwd_policy_pkg::*;
    logic clk_sys, srst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    frame_req_t frame_req;
    frame_dec_t frame_dec;
    queue_code_t [4:0] queue_code;
    logic [7:0] rm [5][4];
    logic [32:0] rd_q [$];
    logic [29:0] dec_q [$];
    int seed = 31, mismatches = 0, compares = 0;
    switch_port_forwarding_policy i_dut (.clk_sys(clk_sys), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .frame_req(frame_req), .frame_dec(frame_dec),
        .queue_code(queue_code));
    task automatic cmp(input string nm, input logic [32:0] ex, input logic [32:0] got);
        compares++;
        if (got !== ex) begin
            mismatches++;
            $display("[FAIL] %s exp=%h got=%h", nm, ex, got);
        end
    endtask : cmp
    task automatic cmp_dec(input logic [29:0] ex, input logic [29:0] got);
        compares++;
        if (got !== ex) begin
            mismatches++;
            $display("[FAIL] dec exp=%h got=%h", ex, got);
        end
    endtask : cmp_dec
    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////
    function automatic logic [29:0] exp_dec(input frame_req_t r);
        logic [4:0] nrm, dst, txs;
        logic [2:0] pr, df;
        frame_dec_t e;
        logic [9:0] qv;
        for (int i = 0; i < 5; i++) begin
            dst[i] = rm[i][1][7];
            txs[i] = rm[i][1][5];
        end
        nrm = r.dest_mask & rm[r.src_port][1][4:0];
        e.monitored = rm[r.src_port][1][6] | |(nrm & txs);
        df = rm[r.src_port][3][7:5];
        pr = (rm[r.src_port][2][7] && r.user_prio > df) ? df : r.user_prio;
        e.valid = 1'b1;
        e.fwd_mask = nrm | (e.monitored ? dst & ~(5'h01 << r.src_port) : 5'h00);
        e.user_prio = pr;
        for (int i = 0; i < 5; i++) begin
            qv[2*i+:2] = rm[i][0][1:0];
            case (rm[i][0][1:0])
                2'b10: e.egress_queue[i] = pr[2:1];
                2'b01: e.egress_queue[i] = {1'b0, pr[2]};
                default: e.egress_queue[i] = 2'b00;
            endcase
        end
        return {e, qv};
    endfunction : exp_dec
    task automatic apb(input logic wr, input int p, input int s, input logic [32:0] ex);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, 4'(p + 1), 4'(s), 2'b00};
        pwdata <= d;
        if (!wr) rd_q.push_back(ex);
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) mismatches++;
        if (n >= 16) end_sim();
    endtask : apb
    task automatic send(input logic v);
        frame_req_t r;
        r = 12'($random(seed));
        r.valid = v;
        r.src_port = 3'($unsigned($random(seed)) % 5);
        frame_req <= r;
        if (v) dec_q.push_back(exp_dec(r));
        @(posedge clk_sys);
    endtask : send
    ////////////////////////////////////////
    always @(posedge clk_sys) begin
        if (!srst && psel && penable && !pwrite && rd_q.size() > 0) begin
            cmp("prdata", rd_q.pop_front(), {pslverr, prdata});
        end
        if (!srst && frame_dec.valid !== 1'b0) begin
            cmp_dec(dec_q.size() ? dec_q.pop_front() : 'x, {frame_dec, queue_code});
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (100000) @(posedge clk_sys);
        mismatches++;
        end_sim();
    end
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, d, frame_req} = 91'h0;
        foreach (rm[p, s]) rm[p][s] = (s == 1) ? 8'h1F : 8'h00;
        repeat (6) @(posedge clk_sys);
        srst <= 1'b0;
        foreach (rm[p, s]) apb(1'b0, p, s, {25'h0, rm[p][s]});
        apb(1'b1, 0, 4, 33'h0);
        apb(1'b0, 0, 4, {1'b1, 32'h0});
        for (int k = 0; k < 8; k++) begin
            foreach (rm[p, s]) begin
                d = $random(seed);
                apb(1'b1, p, s, 33'h0);
                rm[p][s] = s ? d[7:0] : {6'h00, d[1:0]};
            end
            foreach (rm[p, s]) apb(1'b0, p, s, {25'h0, rm[p][s]});
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge clk_sys);
            repeat (40) send($random(seed) % 4 != 0);
            send(1'b0);
        end
        // Mid-run reset must restore every register
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        foreach (rm[p, s]) rm[p][s] = (s == 1) ? 8'h1F : 8'h00;
        foreach (rm[p, s]) apb(1'b0, p, s, {25'h0, rm[p][s]});
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge clk_sys);
        if (dec_q.size() || rd_q.size()) mismatches++;
        end_sim();
    end
endmodule : switch_port_forwarding_policy_tb_top
